// *** core/rts_sequencer.sv ***
// Reset and float-mode sequencer for the chip top.
// Assumes mclk free-running from the board and straps pulled to valid levels.
// Overview of operation
// - Reset pin enters reset at once; release waits on the master clock.
// - First processor fetch is issued eighty clocks after the pin rises.
// - Any reset clears peripheral registers and sends the next fetch to zero.
// - Watchdog reset acts as pin reset but keeps the latched strap modes.
// - Pin reset during a watchdog request is treated as a pin reset.
// - Float strap low for the last ten clocks before release selects float mode.
// - Float mode disables every output pin driver.
// - Clock output is low in reset, then copies the clock until reassigned.
// - After reset every peripheral pad is an input.
// - The float strap shares pad 21 with the serial transmit; strap only in reset.
// - Boot width strap is taken from its last sample before release; one means 8-bit.
// - Remap once commanded is undone only by an internal or pin reset.
`timescale 1ns/10ps

module rts_sequencer #(
   parameter int unsigned FETCH_DELAY = rts_pkg::FETCH_CYCLES,
   parameter int unsigned STRAP_LEN   = rts_pkg::STRAP_CYCLES
) (
   // Clock and external reset pin.
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   // Internal watchdog reset request, on mclk.
   input  wire logic                  wdog_reset_req,
   // Strap pins.
   input  wire logic                  float_select_in,
   input  wire logic                  boot_width_select,
   // Software controls from the chip, on mclk.
   input  wire logic                  remap_command_bit,
   input  wire logic                  clk_pin_as_gpio,
   input  wire logic                  clk_pin_gpio_val,
   input  wire logic [31:0]           pad_oe_req,
   input  wire logic [31:0]           pad_out_req,
   // Reset and fetch outputs.
   output logic                       periph_rst_n,
   output logic                       fetch_start,
   output logic [31:0]                fetch_addr,
   output logic                       remap_active,
   output rts_pkg::rts_modes_t        modes,
   // Pad controls.
   output logic                       clock_out_pin,
   output logic                       clock_out_oe,
   output logic [31:0]                pad_out,
   output logic [31:0]                pad_oe
);
   logic [rts_pkg::SYNC_STAGES-1:0] sync_q;
   logic                            wd_q;
   logic                            pin_seen_q;
   logic [7:0]                      cnt_q;
   logic [STRAP_LEN-1:0]            flt_hist_q;
   logic                            bw_last_q;
   rts_pkg::rts_modes_t             modes_d;
   logic                            latch_modes;
   logic [1:0]                      strap_fs_q;
   logic [1:0]                      strap_bw_q;
   rts_pkg::rts_state_t             state_q;
   logic                            clk_en_q;
   logic                            in_reset;

   // Pin or watchdog holds the sequence; pin wins since it clears asynchronously.
   assign in_reset = (state_q == rts_pkg::RTS_HELD);

   // Release synchroniser: asserts asynchronously, releases on mclk.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         sync_q <= '0;
      else
         sync_q <= {sync_q[rts_pkg::SYNC_STAGES-2:0], 1'b1};
   end

   // Strap inputs are pins, so they pass two flops before anything reads them.
   // They carry no reset, because they must keep sampling while the pin is low.
   always_ff @(posedge mclk)
   begin
      strap_fs_q <= {strap_fs_q[0], float_select_in};
      strap_bw_q <= {strap_bw_q[0], boot_width_select};
   end

   // Watchdog request latch and pin-reset marker; a pin reset overrides both.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wd_q       <= 1'b0;
         pin_seen_q <= 1'b1;
      end
      else
      begin
         wd_q <= wdog_reset_req;
         if (state_q == rts_pkg::RTS_RUN)
            pin_seen_q <= 1'b0;
      end
   end

   // Sequence state and fetch counter. The count starts after the synchroniser.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= rts_pkg::RTS_HELD;
         cnt_q   <= 8'h00;
      end
      else
      begin
         case (state_q)
            rts_pkg::RTS_HELD:
            begin
               cnt_q <= 8'h00;
               if (sync_q[rts_pkg::SYNC_STAGES-1] && !wd_q)
                  state_q <= rts_pkg::RTS_COUNT;
            end
            rts_pkg::RTS_COUNT:
            begin
               cnt_q <= cnt_q + 8'h01;
               // Sync stages plus this count land the fetch on cycle 80.
               if (32'(cnt_q) + 32'(rts_pkg::SYNC_STAGES) + 32'h2 >= FETCH_DELAY)
                  state_q <= rts_pkg::RTS_RUN;
            end
            rts_pkg::RTS_RUN:
            begin
               if (wd_q)
                  state_q <= rts_pkg::RTS_HELD;
            end
            default:
               state_q <= rts_pkg::RTS_HELD;
         endcase
      end
   end

   // Strap window: the last STRAP_LEN samples taken while the synchronised reset
   // is low. No reset on purpose, since the pin reset must not stop the sampling;
   // the running clock the board owes before release flushes power-up values.
   // A watchdog reset keeps the synchroniser high, so the straps are ignored then.
   always_ff @(posedge mclk)
   begin
      if (!sync_q[rts_pkg::SYNC_STAGES-1])
      begin
         flt_hist_q <= {flt_hist_q[STRAP_LEN-2:0], strap_fs_q[1]};
         bw_last_q  <= strap_bw_q[1];
      end
   end

   // Modes load on the first count cycle after a pin reset only.
   assign latch_modes = pin_seen_q && (state_q == rts_pkg::RTS_COUNT) && (cnt_q == 8'h00);

   // Next modes; the pad enables read it too, so float mode never leaves a driver on.
   always_comb
   begin
      modes_d = modes;
      if (latch_modes)
      begin
         modes_d.float_mode = (flt_hist_q == '0);
         modes_d.boot_8bit  = bw_last_q;
      end
   end

   // Modes register; a watchdog reset keeps the latched modes.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         modes <= '0;
      else
         modes <= modes_d;
   end

   // Reset outputs, fetch pulse and remap latch.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         periph_rst_n <= 1'b0;
         fetch_start  <= 1'b0;
         fetch_addr   <= rts_pkg::FETCH_ADDR_RST;
         remap_active <= 1'b0;
      end
      else
      begin
         periph_rst_n <= !in_reset && !wd_q;
         fetch_start  <= (state_q == rts_pkg::RTS_COUNT)
                         && (32'(cnt_q) + 32'(rts_pkg::SYNC_STAGES) + 32'h2 >= FETCH_DELAY);
         fetch_addr   <= rts_pkg::FETCH_ADDR_RST;
         if (in_reset || wd_q)
            remap_active <= 1'b0;
         else if (remap_command_bit)
            remap_active <= 1'b1;
      end
   end

   // Clock output enable: low in reset, since a glitchy edge could fire board logic.
   always_ff @(negedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         clk_en_q <= 1'b0;
      else
         clk_en_q <= !in_reset && !clk_pin_as_gpio;
   end

   // Clock pin copies mclk after reset; gating is on the falling edge so no runt.
   always_ff @(posedge mclk or negedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         clock_out_pin <= 1'b0;
      else if (clk_en_q)
         clock_out_pin <= !clock_out_pin;
      else
         clock_out_pin <= clk_pin_gpio_val && !in_reset;
   end

   // Pad drivers: inputs after reset, all off in float mode.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pad_oe       <= '0;
         pad_out      <= '0;
         clock_out_oe <= 1'b0;
      end
      else
      begin
         pad_out      <= pad_out_req;
         clock_out_oe <= !modes_d.float_mode;
         if (!periph_rst_n || modes_d.float_mode)
            pad_oe <= '0;
         else
            pad_oe <= pad_oe_req;
      end
   end
endmodule

// *** dv/rts_board.sv ***
// Board model: reset source and strap resistors.
// Assumes the bench holds reset_req for at least ten running clocks.
`timescale 1ns/10ps
module rts_board (
   // Clock and requests from the bench.
   input  wire logic mclk,
   input  wire logic reset_req,
   input  wire logic float_req,
   input  wire logic boot_req,
   // Board pins.
   output logic      rst_n,
   output logic      float_select_in,
   output logic      boot_width_select
);
   // Pins follow the requests at once; the bench moves them on the falling edge,
   // so there is no race with a second flop on that same edge.
   assign rst_n             = !reset_req;
   // The pull-up holds the float strap high unless the probe pulls it low.
   assign float_select_in   = !float_req;
   assign boot_width_select = boot_req;
endmodule

// *** dv/rts_sequencer_asserts.sv ***
// Port checker for the reset and float sequencer.
// Assumes it is bound into rts_sequencer with the same fetch delay.
`timescale 1ns/10ps
module rts_sequencer_asserts #(
   parameter int unsigned FETCH_DELAY = rts_pkg::FETCH_CYCLES
) (
   // Clock, pin reset and watchdog request.
   input wire logic                mclk,
   input wire logic                rst_n,
   input wire logic                wdog_reset_req,
   // Watched outputs.
   input wire logic                fetch_start,
   input wire logic [31:0]         fetch_addr,
   input wire logic                remap_active,
   input wire logic                periph_rst_n,
   input wire rts_pkg::rts_modes_t modes,
   input wire logic                clock_out_oe,
   input wire logic [31:0]         pad_oe
);
   // The release synchroniser may shift the fetch by a couple of edges.
   localparam int LO = FETCH_DELAY - 2;
   localparam int HI = FETCH_DELAY + 3;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_fetch_after_release: assert property ($rose(rst_n) |-> ##[LO:HI] fetch_start)
      else $error("fetch start missing after release");
   a_release_synced: assert property ($rose(rst_n) |-> !fetch_start [*3])
      else $error("fetch start too soon after release");
   a_fetch_single: assert property (fetch_start |=> !fetch_start)
      else $error("fetch start longer than one cycle");
   a_fetch_at_zero: assert property (fetch_start |-> fetch_addr == 32'h0000_0000)
      else $error("fetch address not zero");
   a_float_no_drive: assert property (modes.float_mode |-> pad_oe == 32'h0 && !clock_out_oe)
      else $error("driver enabled in float mode");
   a_wdog_keeps_mode: assert property ($past(rst_n, 3) && wdog_reset_req |-> $stable(modes))
      else $error("modes changed in watchdog reset");
   a_wdog_holds_per: assert property (wdog_reset_req |-> ##[0:2] !periph_rst_n)
      else $error("watchdog did not reset peripherals");
   a_remap_undone: assert property (wdog_reset_req |-> ##[0:2] !remap_active)
      else $error("remap kept through watchdog reset");
   a_pads_input: assert property ($rose(periph_rst_n) |-> pad_oe == 32'h0)
      else $error("pad driven at reset exit");
endmodule

bind rts_sequencer rts_sequencer_asserts #(.FETCH_DELAY(FETCH_DELAY)) u_chk (
   .mclk(mclk), .rst_n(rst_n), .wdog_reset_req(wdog_reset_req), .fetch_start(fetch_start),
   .fetch_addr(fetch_addr), .remap_active(remap_active), .periph_rst_n(periph_rst_n),
   .modes(modes), .clock_out_oe(clock_out_oe), .pad_oe(pad_oe));

// *** dv/testbench.sv ***
// Self-checking bench for the reset and float sequencer.
// Assumes the board model drives the pins; shortened counts 8 and 3.
`timescale 1ns/10ps
module testbench;
   logic mclk = 1'h0, rreq = 1'h1, freq = 1'h0, breq = 1'h1, wdog = 1'h0, remap = 1'h0;
   logic gpio = 1'h0, gval = 1'h0;
   logic rst_n, fsel, bsel, per_n, fstart, rmp, cko, cko_oe;
   localparam int FETCH = 8;
   logic [31:0] faddr, pout, poe;
   rts_pkg::rts_modes_t modes;
   int failures = 0, checked = 0, cyc = 0;
   rts_board brd (.mclk(mclk), .reset_req(rreq), .float_req(freq), .boot_req(breq),
      .rst_n(rst_n), .float_select_in(fsel), .boot_width_select(bsel));
   rts_sequencer #(.FETCH_DELAY(FETCH), .STRAP_LEN(3)) dut (.mclk(mclk), .rst_n(rst_n),
      .wdog_reset_req(wdog), .float_select_in(fsel), .boot_width_select(bsel),
      .remap_command_bit(remap), .clk_pin_as_gpio(gpio), .clk_pin_gpio_val(gval),
      .pad_oe_req(32'hFFFF_FFFF), .pad_out_req(32'hA5A5_A5A5), .periph_rst_n(per_n),
      .fetch_start(fstart), .fetch_addr(faddr), .remap_active(rmp), .modes(modes),
      .clock_out_pin(cko), .clock_out_oe(cko_oe), .pad_out(pout), .pad_oe(poe));
   // Free-running clock; the timeout counter rides on it.
   initial forever #25 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         finish_test();
      end
   end
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (exp !== got)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Waits for the fetch pulse under a bound and checks its arrival time.
   task automatic wait_fetch(int lo, int hi);
      int n;
      n = 0;
      while (fstart !== 1'h1 && n < 40)
      begin
         @(negedge mclk);
         n++;
      end
      chk("fetch_start", 32'h1, {31'h0, fstart});
      chk("fetch_time", 32'h1, {31'h0, (n >= lo) && (n <= hi)});
      chk("fetch_addr", 32'h0, faddr);
   endtask
   // Pin reset held twelve clocks with the given straps; wdog may overlap.
   task automatic pin_reset(logic fl, logic bt, logic wd);
      @(negedge mclk);
      {rreq, freq, breq, wdog} = {1'h1, fl, bt, wd};
      repeat (12) @(negedge mclk);
      chk("clock_out_pin", 32'h0, {31'h0, cko});
      chk("pad_oe_rst", 32'h0, poe);
      {rreq, wdog} = 2'h0;
      repeat (2) @(negedge mclk);
      chk("no_early_fetch", 32'h0, {31'h0, fstart});
      // Release fell on a falling edge; the pulse is seen FETCH falling edges later.
      wait_fetch(FETCH - 2, FETCH - 2);
      chk("periph_rst_n_run", 32'h1, {31'h0, per_n});
      chk("modes", {30'h0, fl, bt}, {30'h0, modes});
      repeat (4) @(negedge mclk);
      chk("clock_out_oe", {31'h0, !fl}, {31'h0, cko_oe});
      if (fl)
         chk("pad_oe_float", 32'h0, poe);
      else
         chk("pad_oe_run", 32'hFFFF_FFFF, poe);
      chk("pad_out", 32'hA5A5_A5A5, pout);
   endtask
   // Clock pin copies mclk, then shows the general-purpose value once reassigned.
   task automatic clock_pin();
      @(posedge mclk);
      #10;
      chk("clock_out_high", 32'h1, {31'h0, cko});
      @(negedge mclk);
      #10;
      chk("clock_out_low", 32'h0, {31'h0, cko});
      @(negedge mclk);
      {gpio, gval} = 2'h3;
      repeat (3) @(negedge mclk);
      chk("clock_gpio_high", 32'h1, {31'h0, cko});
      gval = 1'h0;
      @(negedge mclk);
      chk("clock_gpio_low", 32'h0, {31'h0, cko});
      gpio = 1'h0;
   endtask
   // Watchdog reset with changed straps keeps modes and undoes remap.
   task automatic wdog_reset();
      remap = 1'h1;
      repeat (3) @(negedge mclk);
      chk("remap_set", 32'h1, {31'h0, rmp});
      {remap, freq, breq, wdog} = {1'h0, 1'h1, 1'h1, 1'h1};
      repeat (12) @(negedge mclk);
      chk("remap_active", 32'h0, {31'h0, rmp});
      chk("periph_rst_n", 32'h0, {31'h0, per_n});
      wdog = 1'h0;
      wait_fetch(1, 12);
      chk("modes_kept", 32'h0, {30'h0, modes});
   endtask
   task automatic finish_test();
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence: start-up reset, then each scenario.
   initial
   begin
      repeat (3) @(negedge mclk);
      pin_reset(1'h0, 1'h1, 1'h0);
      clock_pin();
      pin_reset(1'h1, 1'h0, 1'h0);
      pin_reset(1'h0, 1'h0, 1'h1);
      wdog_reset();
      finish_test();
   end
endmodule

// *** inc/rts_pkg.sv ***
// Constants and carrier types for the reset and float sequencer.
// Assumes a single master clock of 20 MHz; no software-visible registers.
package rts_pkg;
   // Strap window length in master clock cycles before release.
   localparam int unsigned STRAP_CYCLES = 10;
   // Cycles from release edge to the first processor fetch.
   localparam int unsigned FETCH_CYCLES = 80;
   // Stages of the release synchroniser.
   localparam int unsigned SYNC_STAGES  = 2;
   // Reset value of the fetch address.
   localparam logic [31:0] FETCH_ADDR_RST = 32'h0000_0000;
   // Boot width encodings as sampled on the strap.
   localparam logic BOOT_8BIT  = 1'h1;
   localparam logic BOOT_16BIT = 1'h0;
   // Number of peripheral pads.
   localparam int unsigned PAD_COUNT = 32;
   // Pad index that also carries the float strap.
   localparam int unsigned FLOAT_PAD = 21;

   // Sequencer phases.
   typedef enum logic [1:0] {
      RTS_HELD,
      RTS_COUNT,
      RTS_RUN
   } rts_state_t;

   // Latched strap modes kept across watchdog resets.
   typedef struct packed {
      logic float_mode;
      logic boot_8bit;
   } rts_modes_t;
endpackage
